// *** spd_consts.vh ***
// constants for the serial port status and divider block
// How it works
// (R1) queue-full flag bit 8 follows receive queue full; one more frame fits in shifter
// (R2) data-valid flag bit 7 set while receive queue holds any frame
// (R3) send buffer level bit 6 resets to 1, set when empty or half level
// (R4) send complete bit 5 set when buffer and shifter drain, cleared on write
// (R5) output floating bit 4 shows tristate, always 0 under automatic float
// (R6) discard flag bit 3 drops a frame if set when frame completes
// (R7) controller role bit 2 set by on command, cleared by off command
// (R8) sender on flag bit 1 reflects transmitter enable, 0 after reset
// (R9) receiver on flag bit 0 reflects receiver enable, 0 after reset
// (R10) divider field bits 20:6 read-write, resets to zero, sets bit clock
// (R11) software writes zeros to unused status and divider bits
// (R12) command bit 4 enters controller role, bit 5 returns to target role
// (R13) receiver off command discards a partially received frame
// (R14) all flags update on one clock so a read is coherent
`ifndef SPD_CONSTS_VH
`define SPD_CONSTS_VH
`define SPD_OFF_CMD        12'h00C
`define SPD_OFF_STATUS     12'h010
`define SPD_OFF_CLKDIV     12'h014
`define SPD_OFF_CTRL       12'h040
`define SPD_OFF_IRQ_FLAG   12'h044
`define SPD_OFF_IRQ_MASK   12'h048
`define SPD_CMD_RXEN       0
`define SPD_CMD_RECEIVER_OFF_CMD      1
`define SPD_CMD_TXEN       2
`define SPD_CMD_TXDIS      3
`define SPD_CMD_ROLE_ON    4
`define SPD_CMD_ROLE_OFF   5
`define SPD_CMD_BLK_EN     6
`define SPD_CMD_BLK_DIS    7
`define SPD_CMD_TRI_EN     8
`define SPD_CMD_TRI_DIS    9
`define SPD_CMD_CLEARRX    10
`define SPD_CMD_CLEARTX    11
`define SPD_CTRL_HALF      0
`define SPD_CTRL_AUTOMATIC_OUTPUT_FLOAT   1
`define SPD_DIV_HI         20
`define SPD_DIV_LO         6
`define SPD_DIV_RESET      15'h0000
`define SPD_STATUS_RESET   9'h040
`define SPD_RXQ_DEPTH      2
`define SPD_TXQ_DEPTH      2
`define SPD_IRQ_TXC        0
`define SPD_IRQ_RECEIVE_WORD_VALID    1
`define SPD_IRQ_RECEIVE_QUEUE_FULL     2
`define SPD_IRQ_DROP       3
`endif

// *** spd_status_divider.v ***
// serial port status flags, commands, divider and axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "spd_consts.vh"
module spd_status_divider
(
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // shifter events, same clock
    input  wire        rx_frame_done,
    input  wire        rx_frame_busy,
    input  wire        tx_shift_empty,
    input  wire        tx_frame_done,
    input  wire        rx_pop,
    input  wire        tx_pop,
    // controls to shifters
    output reg  [14:0] bit_clock_div,
    output reg         sender_on_flag,
    output reg         receiver_on_flag,
    output reg         controller_role,
    output reg         output_floating_flag,
    output reg         rx_frame_abort,
    // interrupt
    output reg         irq
);

    reg  [1:0]  rxq_cnt_r;
    reg  [1:0]  txq_cnt_r;
    reg         send_complete_r;
    reg         receive_discard_flag_r;
    reg         tri_req_r;
    reg  [1:0]  ctrl_r;
    reg  [3:0]  irq_flag_r;
    reg  [3:0]  irq_mask_r;
    reg  [11:0] aw_addr_r;
    reg         aw_have_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         w_have_r;

    wire        wr_go  = aw_have_r && w_have_r && !s_axi_bvalid;
    wire        rd_go  = s_axi_arvalid && s_axi_arready;
    wire        lane0  = w_strb_r[0];
    wire        cmd_wr = wr_go && (aw_addr_r[11:2] == `SPD_OFF_CMD >> 2);
    wire [11:0] cmd    = (cmd_wr && lane0) ? {4'h0 & w_strb_r, 8'h00} |
                         {(w_strb_r[1] ? w_data_r[11:8] : 4'h0), w_data_r[7:0]} : 12'h000;
    // transmit buffer write: counts a frame into the send queue and clears send complete; the written data is not stored
    wire        tx_push = wr_go && (aw_addr_r[11:2] == 10'h00D) && lane0;

    wire        rx_full   = (rxq_cnt_r == `SPD_RXQ_DEPTH);
    wire        rx_valid  = (rxq_cnt_r != 2'd0);
    wire        tx_empty  = (txq_cnt_r == 2'd0);
    // (R3) level flag with half option
    wire        tx_level  = ctrl_r[`SPD_CTRL_HALF] ? (txq_cnt_r < 2'd2) : tx_empty;
    // (R5) forced to zero under automatic float
    wire        floating  = tri_req_r && !ctrl_r[`SPD_CTRL_AUTOMATIC_OUTPUT_FLOAT];
    // (R6) decision taken on the flag at frame completion
    wire        rx_load   = rx_frame_done && receiver_on_flag && !receive_discard_flag_r
                            && !rx_full;
    wire        rx_drop   = rx_frame_done && !rx_load;

    // (R14) coherent status snapshot
    wire [8:0]  status = {rx_full, rx_valid, tx_level, send_complete_r, floating,
                          receive_discard_flag_r, controller_role, sender_on_flag,
                          receiver_on_flag};
    wire [3:0]  ev = {rx_drop, rx_load & rx_full, rx_load, tx_frame_done & tx_empty
                      & tx_shift_empty};

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rxq_cnt_r              <= 2'd0;
            txq_cnt_r              <= 2'd0;
            send_complete_r        <= 1'b0;
            receive_discard_flag_r <= 1'b0;
            tri_req_r              <= 1'b0;
            controller_role        <= 1'b0;
            sender_on_flag         <= 1'b0;
            receiver_on_flag       <= 1'b0;
            output_floating_flag   <= 1'b0;
            rx_frame_abort         <= 1'b0;
            bit_clock_div          <= `SPD_DIV_RESET;
            ctrl_r                 <= 2'b00;
            irq_flag_r             <= 4'h0;
            irq_mask_r             <= 4'h0;
            irq                    <= 1'b0;
        end
        else
        begin
            // (R1) queue fill tracks loads and pops; clear command empties it
            if (cmd[`SPD_CMD_CLEARRX])
                rxq_cnt_r <= 2'd0;
            else
                rxq_cnt_r <= rxq_cnt_r + {1'b0, rx_load} - {1'b0, rx_pop && rx_valid};
            if (cmd[`SPD_CMD_CLEARTX])
                txq_cnt_r <= 2'd0;
            else
                txq_cnt_r <= txq_cnt_r + {1'b0, tx_push && txq_cnt_r != `SPD_TXQ_DEPTH}
                             - {1'b0, tx_pop && !tx_empty};
            // (R4) complete set on drain, cleared by new data; set wins
            if (ev[`SPD_IRQ_TXC])
                send_complete_r <= 1'b1;
            else if (tx_push)
                send_complete_r <= 1'b0;
            // (R6) blocking commands
            if (cmd[`SPD_CMD_BLK_EN])
                receive_discard_flag_r <= 1'b1;
            else if (cmd[`SPD_CMD_BLK_DIS])
                receive_discard_flag_r <= 1'b0;
            if (cmd[`SPD_CMD_TRI_EN])
                tri_req_r <= 1'b1;
            else if (cmd[`SPD_CMD_TRI_DIS])
                tri_req_r <= 1'b0;
            output_floating_flag <= floating;
            // (R7) role on and off commands
            if (cmd[`SPD_CMD_ROLE_ON])
                controller_role <= 1'b1;
            else if (cmd[`SPD_CMD_ROLE_OFF])
                controller_role <= 1'b0;
            // (R8) transmitter enable state
            if (cmd[`SPD_CMD_TXEN])
                sender_on_flag <= 1'b1;
            else if (cmd[`SPD_CMD_TXDIS])
                sender_on_flag <= 1'b0;
            // (R9) receiver enable state
            if (cmd[`SPD_CMD_RXEN])
                receiver_on_flag <= 1'b1;
            else if (cmd[`SPD_CMD_RECEIVER_OFF_CMD])
                receiver_on_flag <= 1'b0;
            // (R13) abort a frame in flight on receiver off
            rx_frame_abort <= cmd[`SPD_CMD_RECEIVER_OFF_CMD] && rx_frame_busy;
            if (wr_go && aw_addr_r == `SPD_OFF_CLKDIV)
            begin
                // (R10) divider field, byte lanes honoured
                if (w_strb_r[0])
                    bit_clock_div[1:0] <= w_data_r[7:6];
                if (w_strb_r[1])
                    bit_clock_div[9:2] <= w_data_r[15:8];
                if (w_strb_r[2])
                    bit_clock_div[14:10] <= w_data_r[20:16];
            end
            if (wr_go && aw_addr_r == `SPD_OFF_CTRL && lane0)
                ctrl_r <= w_data_r[1:0];
            if (wr_go && aw_addr_r == `SPD_OFF_IRQ_MASK && lane0)
                irq_mask_r <= w_data_r[3:0];
            // events win over a write-one clear in the same cycle
            if (wr_go && aw_addr_r == `SPD_OFF_IRQ_FLAG && lane0)
                irq_flag_r <= (irq_flag_r & ~w_data_r[3:0]) | ev;
            else
                irq_flag_r <= irq_flag_r | ev;
            irq <= |(irq_flag_r & irq_mask_r);
        end
    end

    // axi4-lite slave: address and data taken in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= 12'h000;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end
        else
        begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_r)
                    `SPD_OFF_CMD, `SPD_OFF_STATUS, `SPD_OFF_CLKDIV, 12'h034,
                    `SPD_OFF_CTRL, `SPD_OFF_IRQ_FLAG, `SPD_OFF_IRQ_MASK:
                        s_axi_bresp <= 2'b00;
                    default:
                        s_axi_bresp <= 2'b10;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case ({s_axi_araddr[11:2], 2'b00})
                    `SPD_OFF_STATUS:   s_axi_rdata <= {23'h0, status};
                    `SPD_OFF_CLKDIV:   s_axi_rdata <= {11'h0, bit_clock_div, 6'h00};
                    `SPD_OFF_CTRL:     s_axi_rdata <= {30'h0, ctrl_r};
                    `SPD_OFF_IRQ_FLAG: s_axi_rdata <= {28'h0, irq_flag_r};
                    `SPD_OFF_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_r};
                    `SPD_OFF_CMD, 12'h034:
                        s_axi_rdata <= 32'h0000_0000;
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // spd_status_divider
`default_nettype wire

// *** spd_status_divider_props.sv ***
// port assertions for the serial port status and divider block
`timescale 1ns/1ps
`default_nettype none
module spd_props
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // shifter side
    input wire logic        rx_frame_busy,
    input wire logic        rx_frame_abort,
    input wire logic [14:0] bit_clock_div,
    input wire logic        sender_on_flag,
    input wire logic        receiver_on_flag,
    input wire logic        controller_role
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence st_rd;
        ar_take ##0 s_axi_araddr == 12'h010;
    endsequence
    sequence dv_rd;
        ar_take ##0 s_axi_araddr == 12'h014;
    endsequence
    role_stat_a: assert property (st_rd |=>
        s_axi_rdata[2:0] == {controller_role, sender_on_flag, receiver_on_flag})
        else $error("status low bits differ from flag ports");
    div_read_a: assert property (dv_rd |=>
        s_axi_rdata == {11'h000, bit_clock_div, 6'h00})
        else $error("divider readback differs from field");
    reset_clear_a: assert property ($rose(aresetn) |->
        bit_clock_div == 15'h0000 && !sender_on_flag && !receiver_on_flag)
        else $error("flags or divider not clear after reset");
    div_write_a: assert property ($changed(bit_clock_div) |-> ##[0:1] s_axi_bvalid)
        else $error("divider changed without a write");
    abort_cause_a: assert property (rx_frame_abort |-> $past(rx_frame_busy))
        else $error("abort without a frame in progress");
    rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
        else $error("read data late");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule // spd_props
bind spd_status_divider spd_props u_props
(
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .rx_frame_busy,
    .rx_frame_abort, .bit_clock_div, .sender_on_flag, .receiver_on_flag, .controller_role
);
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the serial port status and divider block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, rx_frame_done, rx_frame_busy, tx_shift_empty, tx_frame_done;
    logic        rx_pop, tx_pop, sender_on_flag, receiver_on_flag, controller_role;
    logic        output_floating_flag, rx_frame_abort, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, v, seed;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [14:0] bit_clock_div;
    int          error_cnt, checks, rq, tq, aborts;
    bit          rxen, txen, role, blk, tri_f, aut, half, send_complete;
    int          sq[13] = '{0, 4, 6, 8, 2, 1, 3, 5, 7, 9, 0, 2, 8};
    spd_status_divider dut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_frame_done, .rx_frame_busy,
        .tx_shift_empty, .tx_frame_done, .rx_pop, .tx_pop, .bit_clock_div, .sender_on_flag,
        .receiver_on_flag, .controller_role, .output_floating_flag, .rx_frame_abort, .irq
    );
    initial aclk = 1'b0;
    always #5 aclk = ~aclk;
    always @(posedge aclk)
        if (rx_frame_abort === 1'b1)
            aborts++;
    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            $display("mismatch at %0t got %h exp %h", $time, g, e);
            error_cnt++;
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 50)
        begin
            error_cnt++;
            close_out;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] x);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while ((s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) && n < 50)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        tmo(n);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while ((s_axi_arvalid || !s_axi_rvalid) && n < 50)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        tmo(n);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // expected status word from the bench model
    function automatic logic [31:0] st();
        return {23'h000000, rq == 2, rq > 0, half ? tq < 2 : tq == 0, send_complete, tri_f & ~aut,
                blk, role, txen, rxen};
    endfunction
    task automatic cs;
        rd(12'h010);
        chk(d, st());
        chk({31'h0, output_floating_flag}, {31'h0, tri_f & ~aut});
    endtask
    task automatic cmd(input int i);
        // one-hot command word, unused bits zero
        wr(12'h00C, 32'h1 << i);
        case (i)
            0: rxen = 1;
            1: rxen = 0;
            2: txen = 1;
            3: txen = 0;
            4: role = 1;
            5: role = 0;
            6: blk = 1;
            7: blk = 0;
            8: tri_f = 1;
            10: rq = 0;
            11: tq = 0;
            default: tri_f = 0;
        endcase
        cs;
    endtask
    // pulse order: frame in, queue pop, shifter take, frame out
    task automatic ev(input logic [3:0] x);
        @(posedge aclk);
        {rx_frame_done, rx_pop, tx_pop, tx_frame_done} <= x;
        @(posedge aclk);
        {rx_frame_done, rx_pop, tx_pop, tx_frame_done} <= 4'h0;
        rq += (x[3] && rxen && !blk && rq < 2);
        rq -= (x[2] && rq > 0);
        tq -= (x[1] && tq > 0);
        send_complete |= (x[0] && tq == 0 && tx_shift_empty);
    endtask
    task automatic push;
        wr(12'h034, $random(seed) & 32'hFF);
        tq++;
        send_complete = 0;
        cs;
    endtask
    task automatic ck_irq(input logic e);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    initial
    begin
        seed = 32'h98A6;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {rx_frame_done, rx_frame_busy, tx_frame_done, rx_pop, tx_pop, aresetn} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        tx_shift_empty = 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        cs;
        rd(12'h100);
        chk({30'h0, r}, 32'h2);
        chk(d, 32'h0);
        repeat (4)
        begin
            // reserved divider bits written as zero
            v = $random(seed) & 32'h001FFFC0;
            wr(12'h014, v);
            rd(12'h014);
            chk(d, v);
        end
        wr(12'h048, 32'h1);
        wr(12'h044, 32'hF);
        foreach (sq[i])
            cmd(sq[i]);
        wr(12'h040, 32'h2);
        aut = 1;
        cs;
        cmd(9);
        repeat (3)
        begin
            ev(4'h8);
            cs;
        end
        cmd(10);
        ev(4'h8);
        cs;
        cmd(6);
        ev(4'h4);
        ev(4'h8);
        cs;
        cmd(7);
        ev(4'h4);
        cs;
        rx_frame_busy <= 1'b1;
        cmd(1);
        rx_frame_busy <= 1'b0;
        chk(aborts, 1);
        push();
        wr(12'h040, 32'h3);
        half = 1;
        cs;
        push();
        ev(4'h2);
        ev(4'h2);
        tx_shift_empty <= 1'b0;
        ev(4'h1);
        cs;
        tx_shift_empty <= 1'b1;
        ev(4'h1);
        cs;
        ck_irq(1'b1);
        wr(12'h048, 32'h0);
        ck_irq(1'b0);
        wr(12'h048, 32'h1);
        ck_irq(1'b1);
        wr(12'h044, 32'h1);
        ck_irq(1'b0);
        push();
        cmd(11);
        close_out;
    end
endmodule // testbench
`default_nettype wire
